// File: dv/dpc_sva.sv
// checker on dpc_top ports
`timescale 1ns/1ps
module dpc_sva (
    input wire logic                 clk,       // sample clock
    input wire logic                 rst,       // sync reset, high
    input wire logic [7:0]           reg_addr,  // register address
    input wire logic [7:0]           reg_wdata, // write data
    input wire logic                 reg_wr,    // write strobe
    input wire logic                 reg_rd,    // read strobe
    input wire logic [7:0]           reg_rdata, // read data
    input wire logic [1:0]           out_res,   // resolution code
    input wire dpc_pkg::dpc_sample_t in_sample, // input sample
    input wire logic                 in_valid,  // sample present
    input wire logic                 in_ready,  // sample taken
    input wire dpc_pkg::dpc_word_t   out_word,  // output word
    input wire logic                 out_valid, // word present
    input wire logic                 out_ready, // receiver takes word
    input wire logic [dpc_pkg::PAT_W-1:0] frame_clock_pattern // pattern
);
    import dpc_pkg::*;
    // ********
    // software state shadow
    // ********
    logic [7:0]       fpc_s;
    logic [7:0]       dsu_s;
    logic [PAT_W-1:0] pat_s;
    logic             scr_s;
    logic             bypass;
    logic             q_zero;
    always_ff @(posedge clk) begin
        if (rst) begin
            fpc_s <= FPC_RST;
            dsu_s <= DSU_RST;
            pat_s <= PAT_RST;
            scr_s <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                ADDR_FPC:     fpc_s <= reg_wdata & 8'h1e;
                ADDR_DSU:     dsu_s <= reg_wdata & 8'hf9;
                ADDR_PAT_LO:  pat_s[7:0] <= reg_wdata;
                ADDR_PAT_MID: pat_s[15:8] <= reg_wdata;
                ADDR_PAT_HI: begin
                    pat_s[19:16] <= reg_wdata[3:0];
                    scr_s <= reg_wdata[6];
                end
                default: ;
            endcase
        end
    end
    assign bypass = !fpc_s[2] || !fpc_s[1] || dsu_s[6:4] == 3'h0;
    assign q_zero = out_word.a_q == 18'h0 && out_word.b_q == 18'h0;
    function automatic logic [PAT_W-1:0] auto_pat(logic [1:0] r);
        return (r == 2'b01) ? 20'hff000 :
               (r == 2'b10) ? 20'hfe000 : 20'hff800;
    endfunction
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_fpc_readback: assert property (
        reg_rd && reg_addr == 8'h24 |=> reg_rdata == $past(fpc_s))
        else $error("path ctrl read wrong");
    chk_dsu_readback: assert property (
        reg_rd && reg_addr == 8'h25 |=> reg_rdata == $past(dsu_s))
        else $error("setup read wrong");
    chk_unmapped_read: assert property (
        reg_rd && !(reg_addr inside {8'h20, 8'h21, 8'h22, 8'h24, 8'h25})
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_auto_pattern: assert property (
        bypass |=> frame_clock_pattern == auto_pat($past(out_res)))
        else $error("bypass frame pattern wrong");
    chk_stored_pattern: assert property (
        !bypass |=> frame_clock_pattern == $past(pat_s))
        else $error("stored pattern unused");
    chk_bypass_plain: assert property (
        out_valid && !fpc_s[2] |-> q_zero)
        else $error("bypass word altered");
    chk_real_no_mix: assert property (
        out_valid && fpc_s[2] && fpc_s[1] && dsu_s[3] && !scr_s |-> q_zero)
        else $error("real decimation mixed");
    chk_dec_off_plain: assert property (
        out_valid && fpc_s[2] && !fpc_s[1] && !scr_s |-> q_zero)
        else $error("decimator off but mixed");
    chk_word_hold: assert property (
        out_valid && !out_ready |=> out_valid && $stable(out_word))
        else $error("word lost under stall");
endmodule
bind dpc_top dpc_sva dpc_sva_inst (.*);

// File: dv/testbench.sv
// bench for dpc_top
`timescale 1ns/1ps
module testbench;
    import dpc_pkg::*;
    logic             clk = 0;
    logic             rst = 1;
    logic [7:0]       reg_addr = 0;
    logic [7:0]       reg_wdata = 0;
    logic             reg_wr = 0;
    logic             reg_rd = 0;
    logic [7:0]       reg_rdata;
    logic [1:0]       out_res = 0;
    dpc_sample_t      in_sample = 0;
    logic             in_valid = 0;
    logic             in_ready;
    dpc_word_t        out_word;
    logic             out_valid;
    logic             out_ready = 0;
    logic [PAT_W-1:0] frame_clock_pattern;
    logic             stall = 0;
    logic             rd_d = 0;
    logic [31:0]      seed = 32'd18;
    logic [31:0]      t;
    logic [71:0]      wq[$];
    logic [71:0]      rq[$];
    int               num_errors = 0;
    int               num_checks = 0;
    dpc_top dpc_top_inst (.*);
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #2000000;
        num_errors++;
        final_report();
    end
    // ********
    // helpers
    // ********
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [17:0] r18();
        return 18'(rnd());
    endfunction
    function automatic logic [35:0] mix(logic [17:0] x, int p, logic inv);
        logic [17:0] v;
        v = (p < 2) ? x : -x;
        return p[0] ? {18'h0, inv ? v : -v} : {v, 18'h0};
    endfunction
    task automatic check(logic [71:0] seen, logic [71:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1;
        @(posedge clk);
        reg_wr <= 0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1;
        rq.push_back({64'h0, e});
        @(posedge clk);
        reg_rd <= 0;
        @(posedge clk);
    endtask
    task automatic send(logic [17:0] a, logic [17:0] b);
        int n;
        in_sample <= {a, b};
        in_valid <= 1;
        for (n = 0; n < 300; n++) begin
            @(posedge clk);
            if (in_ready === 1'b1) break;
        end
        if (n >= 300) begin
            num_errors++;
            final_report();
        end
    endtask
    task automatic drain();
        int n;
        in_valid <= 0;
        for (n = 0; n < 300 && wq.size() > 0; n++) @(posedge clk);
        if (wq.size() > 0) begin
            num_errors++;
            final_report();
        end
        @(posedge clk);
    endtask
    task automatic do_reset(int n);
        rst <= 1;
        repeat (n) @(posedge clk);
        rst <= 0;
        @(posedge clk);
    endtask
    // receiver with random stalls; checks oldest note
    always @(posedge clk) begin
        t = rnd();
        out_ready <= !stall && t[0];
        rd_d <= reg_rd && !rst;
        if (rd_d)
            check({64'h0, reg_rdata}, rq.pop_front());
        if (out_valid === 1'b1 && out_ready) begin
            if (wq.size() == 0)
                check(out_word, 72'h0);
            else
                check(out_word, wq.pop_front());
        end
    end
    // ********
    // scenarios
    // ********
    initial begin
        logic [17:0] a, b;
        logic signed [ACC_W-1:0] sa, sb;
        int k, r, p;
        logic [7:0] ra[4] = '{8'h24, 8'h25, 8'h22, 8'h30};
        logic [7:0] re[4] = '{8'h1e, 8'hf9, 8'h4f, 8'h00};
        logic [7:0] sf[3] = '{8'h0c, 8'h0c, 8'h04};
        logic [7:0] sd[3] = '{8'h00, 8'h80, 8'h80};
        logic [PAT_W-1:0] rp[3] = '{20'hff800, 20'hff000, 20'hfe000};
        do_reset(20);
        rd(8'h24, 8'h00);
        rd(8'h25, 8'h00);
        rd(8'h20, 8'h00);
        rd(8'h21, 8'hfc);
        rd(8'h22, 8'h0f);
        for (k = 0; k < 4; k++) begin
            wr(ra[k], 8'hff);
            rd(ra[k], re[k]);
        end
        wr(8'h24, 8'h00);
        wr(8'h25, 8'h00);
        wr(8'h22, 8'h4f); // scrambler on while path bypassed
        for (k = 0; k < 3; k++) begin
            out_res <= k[1:0];
            repeat (2) @(posedge clk);
            check(frame_clock_pattern, rp[k]);
        end
        for (k = 0; k < 8; k++) begin
            a = r18();
            b = r18();
            wq.push_back({a, 18'h0, b, 18'h0});
            send(a, b);
        end
        stall <= 1;
        p = 0;
        a = r18();
        b = r18();
        in_sample <= {a, b};
        for (k = 0; k < 12; k++) begin
            @(posedge clk);
            if (in_ready === 1'b1) begin
                wq.push_back({a, 18'h0, b, 18'h0});
                a = r18();
                b = r18();
                in_sample <= {a, b};
            end else
                p++;
        end
        check({71'h0, p > 0}, 72'h1);
        stall <= 0;
        drain();
        wr(8'h22, 8'h0f);
        for (k = 0; k < 3; k++) begin
            wr(8'h24, sf[k]);
            wr(8'h25, sd[k]);
            repeat (4) begin
                a = r18();
                b = r18();
                wq.push_back({a, 18'h0, k == 1 ? a : b, 18'h0});
                send(a, b);
            end
            drain();
        end
        wr(8'h24, 8'h06);
        for (r = 0; r < 6; r++) begin
            wr(8'h25, {1'b0, r[2:0], 4'h8});
            sa = 0;
            sb = 0;
            for (k = 0; k < (1 << r); k++) begin
                a = r18();
                b = r18();
                sa = sa + {{5{a[17]}}, a};
                sb = sb + {{5{b[17]}}, b};
                if (k == (1 << r) - 1) begin
                    sa = sa >>> r;
                    sb = sb >>> r;
                    wq.push_back({sa[17:0], 18'h0, sb[17:0], 18'h0});
                end
                send(a, b);
            end
            drain();
        end
        for (k = 0; k < 3; k++) begin
            out_res <= k[1:0];
            wr(8'h20, rp[k][7:0]);
            wr(8'h21, rp[k][15:8]);
            wr(8'h22, {4'h0, rp[k][19:16]});
            @(posedge clk);
            check(frame_clock_pattern, rp[k]);
        end
        out_res <= 2'b00;
        for (p = 0; p < 2; p++) begin
            do_reset(2);
            wr(8'h24, 8'h06);
            wr(8'h25, {7'h0, p[0]});
            for (k = 0; k < 8; k++) begin
                a = r18();
                b = r18();
                wq.push_back({mix(a, k % 4, p[0]),
                              mix(b, k % 4, p[0])});
                send(a, b);
            end
            drain();
        end
        do_reset(2);
        wr(8'h22, 8'h4f);
        wr(8'h24, 8'h04);
        a = r18();
        b = r18();
        wq.push_back(~{a, 18'h0, b, 18'h0});
        send(a, b);
        drain();
        final_report();
    end
endmodule

// File: hdl/dpc_skid.sv
// two-entry skid buffer between the feature path and the sample receiver
`timescale 1ns/1ps
module dpc_skid (
    input  wire logic               clk,       // sample clock
    input  wire logic               rst,       // sync reset, high
    input  wire dpc_pkg::dpc_word_t in_data,   // word from the path
    input  wire logic               in_valid,  // word present
    output logic                    in_ready,  // buffer can take a word
    output dpc_pkg::dpc_word_t      out_data,  // word to receiver
    output logic                    out_valid, // word present
    input  wire logic               out_ready  // receiver takes word
);
    import dpc_pkg::*;

    dpc_word_t skid_data;

    // ****************************************************************
    // storage
    // ****************************************************************
    // in_ready is kept as the inverse of the skid slot so that it is a
    // flop; a word arriving while the receiver stalls parks in the slot
    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid <= 1'b0;
            in_ready  <= 1'b1;
            out_data  <= '0;
            skid_data <= '0;
        end else if (!out_valid || out_ready) begin
            if (!in_ready) begin
                out_data  <= skid_data;
                out_valid <= 1'b1;
                in_ready  <= 1'b1;
            end else begin
                out_valid <= in_valid;
                if (in_valid) begin
                    out_data <= in_data;
                end
            end
        end else if (in_valid && in_ready) begin
            skid_data <= in_data;
            in_ready  <= 1'b0;
        end
    end

endmodule

// File: hdl/dpc_top.sv
// decimation path control: registers, selector, mixer, decimator, scrambler
//
// What this block does
// - selector 00 feeds A only, 01 both
// - selector code ignored unless selector enable set
// - path enable clear bypasses features, lowest latency
// - decimator enable switches filtering for both channels
// - rate field picks decimation 1 to 32
// - real output low-pass only, else complex mixing
// - phase invert bit negates mixer phase
// - scrambler needs own enable and path enable
// - frame pattern resets, auto-adjusted in bypass
//
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module dpc_top (
    input  wire logic                 clk,          // 25 MHz sample clock
    input  wire logic                 rst,          // sync reset, high
    input  wire logic [7:0]           reg_addr,     // register address
    input  wire logic [7:0]           reg_wdata,    // write data
    input  wire logic                 reg_wr,       // write strobe
    input  wire logic                 reg_rd,       // read strobe
    output logic [7:0]                reg_rdata,    // read data, next cycle
    input  wire logic [1:0]           out_res,      // output resolution code
    input  wire dpc_pkg::dpc_sample_t in_sample,    // channel A and B
    input  wire logic                 in_valid,     // sample present
    output logic                      in_ready,     // sample taken
    output dpc_pkg::dpc_word_t        out_word,     // processed word
    output logic                      out_valid,    // word present
    input  wire logic                 out_ready,    // receiver takes word
    output logic [dpc_pkg::PAT_W-1:0] frame_clock_pattern // active pattern
);
    import dpc_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    logic [7:0]       feature_path_control;
    logic [7:0]       decimation_setup;
    logic [PAT_W-1:0] pattern_reg;
    logic             scrambler_enable;

    logic [1:0] filter_input_select;
    logic       feature_path_enable;
    logic       decimator_enable;
    logic       selector_enable;
    logic       real_out;
    logic       phase_invert;
    dpc_rate_t  rate;

    assign filter_input_select =
        feature_path_control[FPC_SEL_LSB +: 2];
    assign feature_path_enable = feature_path_control[FPC_PATH_BIT];
    assign decimator_enable    = feature_path_control[FPC_DEC_BIT];
    assign selector_enable     = decimation_setup[DSU_SELEN_BIT];
    assign real_out            = decimation_setup[DSU_REAL_BIT];
    assign phase_invert        = decimation_setup[DSU_INV_BIT];
    assign rate = dpc_rate_t'(decimation_setup[DSU_RATE_LSB +: 3]);

    // reserved bits are dropped on write so they always read zero
    always_ff @(posedge clk) begin
        if (rst) begin
            feature_path_control <= FPC_RST;
            decimation_setup     <= DSU_RST;
            pattern_reg          <= PAT_RST;
            scrambler_enable     <= 1'b0;
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADDR_FPC: feature_path_control <= reg_wdata & FPC_MASK;
                ADDR_DSU: decimation_setup     <= reg_wdata & DSU_MASK;
                ADDR_PAT_LO:  pattern_reg[7:0]  <= reg_wdata;
                ADDR_PAT_MID: pattern_reg[15:8] <= reg_wdata;
                ADDR_PAT_HI: begin
                    pattern_reg[19:16] <= reg_wdata[3:0];
                    scrambler_enable   <= reg_wdata[PAT_SCR_BIT];
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                ADDR_FPC:     reg_rdata <= feature_path_control;
                ADDR_DSU:     reg_rdata <= decimation_setup;
                ADDR_PAT_LO:  reg_rdata <= pattern_reg[7:0];
                ADDR_PAT_MID: reg_rdata <= pattern_reg[15:8];
                ADDR_PAT_HI:  reg_rdata <= {1'b0, scrambler_enable,
                                            2'b00, pattern_reg[19:16]};
                default:      reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ****************************************************************
    // frame clock pattern
    // ****************************************************************
    logic dec_bypass;
    logic [PAT_W-1:0] next_pattern;

    assign dec_bypass = !feature_path_enable || !decimator_enable ||
                        (rate == RATE_NONE);

    // in decimation bypass the pattern follows the resolution; the
    // stored value is kept untouched for when decimation returns
    always_comb begin
        next_pattern = pattern_reg;
        if (dec_bypass) begin
            unique case (out_res)
                RES_16:  next_pattern = PAT_AUTO_16;
                RES_14:  next_pattern = PAT_AUTO_14;
                default: next_pattern = PAT_AUTO_18;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            frame_clock_pattern <= PAT_RST;
        end else begin
            frame_clock_pattern <= next_pattern;
        end
    end

    // ****************************************************************
    // input stage and selector
    // ****************************************************************
    logic        advance;
    logic        s1_valid;
    dpc_sample_t s1;
    logic [DATA_W-1:0] x_b;

    // the whole pipeline stalls with the buffer, so nothing is dropped
    assign advance = in_ready;

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_valid <= 1'b0;
            s1       <= '0;
        end else if (advance) begin
            s1_valid <= in_valid;
            s1       <= in_sample;
        end
    end

    always_comb begin
        x_b = s1.b;
        if (selector_enable && filter_input_select == SEL_A_BOTH) begin
            x_b = s1.a;
        end
    end

    // ****************************************************************
    // mixer
    // ****************************************************************
    dpc_phase_t phase;
    dpc_phase_t next_phase;
    logic       dsp_on;
    logic       take;

    assign dsp_on = feature_path_enable && decimator_enable;
    assign take   = advance && s1_valid && feature_path_enable;

    function automatic logic [2*ACC_W-1:0] mix(
        input logic signed [ACC_W-1:0] x,
        input dpc_phase_t              ph,
        input logic                    inv,
        input logic                    is_real
    );
        logic signed [ACC_W-1:0] i_v;
        logic signed [ACC_W-1:0] q_v;
        i_v = x;
        q_v = '0;
        if (!is_real) begin
            unique case (ph)
                PH_0: begin
                    i_v = x;
                    q_v = '0;
                end
                PH_90: begin
                    i_v = '0;
                    q_v = -x;
                end
                PH_180: begin
                    i_v = -x;
                    q_v = '0;
                end
                PH_270: begin
                    i_v = '0;
                    q_v = x;
                end
            endcase
            if (inv) begin
                q_v = -q_v;
            end
        end
        return {i_v, q_v};
    endfunction

    always_comb begin
        next_phase = phase;
        if (take && dsp_on && !real_out) begin
            next_phase = dpc_phase_t'(phase + 2'b01);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            phase <= PH_0;
        end else begin
            phase <= next_phase;
        end
    end

    // ****************************************************************
    // decimator
    // ****************************************************************
    logic signed [ACC_W-1:0] ext_a;
    logic signed [ACC_W-1:0] ext_b;
    logic signed [ACC_W-1:0] x_in [4];
    logic signed [ACC_W-1:0] acc  [4];
    logic signed [ACC_W-1:0] sum  [4];
    logic [4:0] cnt;
    logic [4:0] last;
    logic [2:0] shift;
    logic       s2_valid;
    dpc_word_t  s2;

    assign ext_a = ACC_W'(signed'(s1.a));
    assign ext_b = ACC_W'(signed'(x_b));

    // unused rate codes fall back to no decimation
    always_comb begin
        shift = 3'h0;
        if (dsp_on) begin
            unique case (rate)
                RATE_NONE: shift = 3'h0;
                RATE_2:    shift = 3'h1;
                RATE_4:    shift = 3'h2;
                RATE_8:    shift = 3'h3;
                RATE_16:   shift = 3'h4;
                RATE_32:   shift = 3'h5;
                default:   shift = 3'h0;
            endcase
        end
        last = 5'((6'h01 << shift) - 6'h01);
    end

    always_comb begin
        if (dsp_on) begin
            {x_in[0], x_in[1]} = mix(ext_a, phase, phase_invert, real_out);
            {x_in[2], x_in[3]} = mix(ext_b, phase, phase_invert, real_out);
        end else begin
            x_in[0] = ext_a;
            x_in[1] = '0;
            x_in[2] = ext_b;
            x_in[3] = '0;
        end
        for (int k = 0; k < 4; k++) begin
            sum[k] = acc[k] + x_in[k];
        end
    end

    // boxcar average: accumulate then dump, scaled by the factor; cheap
    // but its stopband is poor compared with a proper half-band chain
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt      <= 5'h00;
            s2_valid <= 1'b0;
            s2       <= '0;
            for (int k = 0; k < 4; k++) begin
                acc[k] <= '0;
            end
        end else if (advance) begin
            s2_valid <= 1'b0;
            if (take) begin
                if (cnt >= last) begin
                    cnt      <= 5'h00;
                    s2_valid <= 1'b1;
                    s2.a_i   <= DATA_W'(sum[0] >>> shift);
                    s2.a_q   <= DATA_W'(sum[1] >>> shift);
                    s2.b_i   <= DATA_W'(sum[2] >>> shift);
                    s2.b_q   <= DATA_W'(sum[3] >>> shift);
                    for (int k = 0; k < 4; k++) begin
                        acc[k] <= '0;
                    end
                end else begin
                    cnt <= cnt + 5'h01;
                    for (int k = 0; k < 4; k++) begin
                        acc[k] <= sum[k];
                    end
                end
            end
        end
    end

    // ****************************************************************
    // scrambler
    // ****************************************************************
    logic [LFSR_W-1:0] lfsr;
    logic [DATA_W-1:0] mask;
    logic              scr_on;
    logic              s3_valid;
    dpc_word_t         s3;

    assign scr_on = scrambler_enable && feature_path_enable;

    always_comb begin
        for (int k = 0; k < DATA_W; k++) begin
            mask[k] = lfsr[k % LFSR_W];
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            lfsr     <= LFSR_SEED;
            s3_valid <= 1'b0;
            s3       <= '0;
        end else if (advance) begin
            s3_valid <= s2_valid && feature_path_enable;
            s3       <= s2;
            if (s2_valid && scr_on) begin
                s3   <= s2 ^ {mask, mask, mask, mask};
                lfsr <= {lfsr[LFSR_W-2:0], lfsr[14] ^ lfsr[13]};
            end
        end
    end

    // ****************************************************************
    // path select and output buffer
    // ****************************************************************
    dpc_word_t buf_data;
    logic      buf_valid;

    // bypass takes the input stage straight to the buffer; words in
    // flight when the path is switched are lost, so switch while idle
    always_comb begin
        if (feature_path_enable) begin
            buf_data  = s3;
            buf_valid = s3_valid;
        end else begin
            buf_data  = '{a_i: s1.a, a_q: '0, b_i: s1.b, b_q: '0};
            buf_valid = s1_valid;
        end
    end

    dpc_skid u_skid (
        .clk       (clk),
        .rst       (rst),
        .in_data   (buf_data),
        .in_valid  (buf_valid),
        .in_ready  (in_ready),
        .out_data  (out_word),
        .out_valid (out_valid),
        .out_ready (out_ready)
    );

endmodule

// File: pkg/dpc_pkg.sv
// package: register map, field layout, codes and carriers of the feature path
package dpc_pkg;

    // ****************************************************************
    // widths
    // ****************************************************************
    localparam int DATA_W = 18;
    localparam int ACC_W  = DATA_W + 5;
    localparam int LFSR_W = 15;
    localparam int PAT_W  = 20;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_PAT_LO  = 8'h20;
    localparam logic [7:0] ADDR_PAT_MID = 8'h21;
    localparam logic [7:0] ADDR_PAT_HI  = 8'h22;
    localparam logic [7:0] ADDR_FPC     = 8'h24;
    localparam logic [7:0] ADDR_DSU     = 8'h25;

    // ****************************************************************
    // field positions and writable masks
    // ****************************************************************
    localparam int FPC_SEL_LSB   = 3;
    localparam int FPC_PATH_BIT  = 2;
    localparam int FPC_DEC_BIT   = 1;
    localparam int DSU_SELEN_BIT = 7;
    localparam int DSU_RATE_LSB  = 4;
    localparam int DSU_REAL_BIT  = 3;
    localparam int DSU_INV_BIT   = 0;
    localparam int PAT_SCR_BIT   = 6;
    localparam logic [7:0] FPC_MASK    = 8'h1e;
    localparam logic [7:0] DSU_MASK    = 8'hf9;
    localparam logic [7:0] PAT_HI_MASK = 8'h4f;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic [7:0]       FPC_RST   = 8'h00;
    localparam logic [7:0]       DSU_RST   = 8'h00;
    localparam logic [PAT_W-1:0] PAT_RST   = 20'hffc00;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 15'h7fff;

    // ****************************************************************
    // codes
    // ****************************************************************
    localparam logic [1:0] SEL_A_ONLY = 2'b00;
    localparam logic [1:0] SEL_A_BOTH = 2'b01;
    localparam logic [1:0] RES_18 = 2'b00;
    localparam logic [1:0] RES_16 = 2'b01;
    localparam logic [1:0] RES_14 = 2'b10;
    localparam logic [PAT_W-1:0] PAT_AUTO_18 = 20'hff800;
    localparam logic [PAT_W-1:0] PAT_AUTO_16 = 20'hff000;
    localparam logic [PAT_W-1:0] PAT_AUTO_14 = 20'hfe000;

    typedef enum logic [2:0] {
        RATE_NONE = 3'b000,
        RATE_2    = 3'b001,
        RATE_4    = 3'b010,
        RATE_8    = 3'b011,
        RATE_16   = 3'b100,
        RATE_32   = 3'b101
    } dpc_rate_t;

    typedef enum logic [1:0] {
        PH_0   = 2'b00,
        PH_90  = 2'b01,
        PH_180 = 2'b10,
        PH_270 = 2'b11
    } dpc_phase_t;

    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic [DATA_W-1:0] a;
        logic [DATA_W-1:0] b;
    } dpc_sample_t;

    typedef struct packed {
        logic [DATA_W-1:0] a_i;
        logic [DATA_W-1:0] a_q;
        logic [DATA_W-1:0] b_i;
        logic [DATA_W-1:0] b_q;
    } dpc_word_t;

endpackage
